// File: include/readback_select_pkg.sv
// package: constants and types for the serial readback-select block
package readback_select_pkg;

    // ------------------------------------------------------------
    // serial frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 24;
    localparam int PAYLOAD_BITS = 16;
    localparam int MODE_TOP = 23;
    localparam int FUNC_TOP = 21;
    localparam int FUNC_LOW = 16;
    localparam logic [1:0] MODE_SPECIAL = 2'h0;
    localparam logic [5:0] FUNC_NOP = 6'h00;
    localparam logic [5:0] FUNC_READ_SELECT = 6'h05;

    // ------------------------------------------------------------
    // readback selection codes (top nine payload bits)
    // ------------------------------------------------------------
    localparam logic [2:0] SEL_INPUT_A = 3'h0;
    localparam logic [2:0] SEL_INPUT_B = 3'h1;
    localparam logic [2:0] SEL_OFFSET_TRIM = 3'h2;
    localparam logic [2:0] SEL_GAIN_TRIM = 3'h3;
    localparam logic [5:0] CHAN_BASE = 6'h08;
    localparam logic [8:0] SEL_CONTROL = 9'h101;
    localparam logic [8:0] SEL_GROUP0_OFFSET = 9'h102;
    localparam logic [8:0] SEL_GROUP1_OFFSET = 9'h103;
    localparam logic [8:0] SEL_AB_GROUP0 = 9'h106;
    localparam logic [8:0] SEL_AB_GROUP1 = 9'h107;
    localparam logic [8:0] SEL_GPIO_LEVEL = 9'h10B;

    // ------------------------------------------------------------
    // wishbone register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_GROUP0_OFFSET = 8'h08;
    localparam logic [7:0] ADDR_GROUP1_OFFSET = 8'h0C;
    localparam logic [7:0] ADDR_AB_GROUP0 = 8'h10;
    localparam logic [7:0] ADDR_AB_GROUP1 = 8'h14;
    localparam logic [7:0] ADDR_CHAN_BASE = 8'h40;
    localparam logic [4:0] CONTROL_RESET = 5'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_NONE = 3'h0,
        SRC_CHANNEL = 3'h1,
        SRC_CONTROL = 3'h3,
        SRC_GROUP0 = 3'h2,
        SRC_GROUP1 = 3'h6,
        SRC_AB0 = 3'h7,
        SRC_AB1 = 3'h5,
        SRC_GPIO = 3'h4
    } source_type;

    typedef struct packed {
        logic sclk;
        logic syncN;
        logic sdi;
    } serial_in_type;

    typedef struct packed {
        logic [1:0] kind;
        logic [2:0] channel;
    } chan_sel_type;

endpackage : readback_select_pkg

// File: verilog/readback_register_select.sv
// design: serial readback-select decoder with wishbone register file
`timescale 1ns/1ps
`default_nettype none

// Contract
// - mode 00, function 000101 selects readback
// - types 000-011, channels 001000 to 001111
// - 100000110 selects group 0 A/B register
// - 100000111 selects group 1 A/B register
// - 100001011 returns gpio level in lsb
// - low seven bits ignored except gpio; the code ignores them for the gpio select too
// - select frame, then nop frame shifts data
module readback_register_select #(
    parameter int CHANNELS = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire readback_select_pkg::serial_in_type serialIn,
    input wire logic gpioLevel,
    output logic sdo,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    import readback_select_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    serial_in_type syncA;
    serial_in_type syncB;
    logic gpioA;
    logic gpioB;
    // previous synced clock level, for edge detection
    logic sclkLast;

    // two stages for every pin; only stage b is read by logic
    always_ff @(posedge clk) begin
        if (srst) begin
            syncA <= '{sclk: 1'b0, syncN: 1'b1, sdi: 1'b0};
            syncB <= '{sclk: 1'b0, syncN: 1'b1, sdi: 1'b0};
            gpioA <= 1'b0;
            gpioB <= 1'b0;
            sclkLast <= 1'b0;
        end else begin
            syncA <= serialIn;
            syncB <= syncA;
            gpioA <= gpioLevel;
            gpioB <= gpioA;
            sclkLast <= syncB.sclk;
        end
    end

    logic sclkFall;
    logic sclkRise;
    // edges of the synced link clock, one cycle wide
    assign sclkFall = sclkLast & ~syncB.sclk;
    assign sclkRise = ~sclkLast & syncB.sclk;

    // ------------------------------------------------------------
    // frame shifter
    // ------------------------------------------------------------
    logic [FRAME_BITS-1:0] shiftIn;
    logic [4:0] bitCount;
    logic frameActive;
    logic frameDone;

    // data taken on falling sclk while sync is low
    always_ff @(posedge clk) begin
        if (srst) begin
            shiftIn <= '0;
            bitCount <= 5'h00;
            frameActive <= 1'b0;
        end else if (syncB.syncN) begin
            bitCount <= 5'h00;
            frameActive <= 1'b0;
        end else begin
            frameActive <= 1'b1;
            if (sclkFall && bitCount < 5'(FRAME_BITS)) begin
                shiftIn <= {shiftIn[FRAME_BITS-2:0], syncB.sdi};
                bitCount <= bitCount + 5'h01;
            end
        end
    end

    // the last falling edge inside the frame ends the decode
    assign frameDone = (bitCount == 5'(FRAME_BITS) - 5'h01) && sclkFall
        && !syncB.syncN;

    logic [FRAME_BITS-1:0] frameWord;
    // whole frame, including the bit taken at this edge
    assign frameWord = {shiftIn[FRAME_BITS-2:0], syncB.sdi};

    // ------------------------------------------------------------
    // registers readable back
    // ------------------------------------------------------------
    logic [4:0] controlValue;
    logic [13:0] group0OffsetValue;
    logic [13:0] group1OffsetValue;
    logic [3:0] abGroup0;
    logic [3:0] abGroup1;
    // sixteen-bit words of the four channel register types
    logic [15:0] channelWord [4][CHANNELS];

    // ------------------------------------------------------------
    // readback decode
    // ------------------------------------------------------------
    source_type next_source;
    chan_sel_type next_chan;
    source_type source;
    chan_sel_type chanSel;
    logic [15:0] payload;
    // the low sixteen frame bits carry the selection
    assign payload = frameWord[PAYLOAD_BITS-1:0];

    // decode looks only at the top nine bits, low seven ignored
    always_comb begin
        next_source = SRC_NONE;
        next_chan = '{kind: 2'h0, channel: 3'h0};
        if (payload[15] == 1'b0
            && payload[12:7] >= CHAN_BASE
            && payload[12:7] < CHAN_BASE + 6'(CHANNELS)) begin
            next_source = SRC_CHANNEL;
            next_chan.kind = payload[14:13];
            next_chan.channel = 3'(payload[9:7]);
        end else begin
            // low bits are not part of the match
            case (payload[15:7])
                SEL_CONTROL: next_source = SRC_CONTROL;
                SEL_GROUP0_OFFSET: next_source = SRC_GROUP0;
                SEL_GROUP1_OFFSET: next_source = SRC_GROUP1;
                SEL_AB_GROUP0: next_source = SRC_AB0;
                SEL_AB_GROUP1: next_source = SRC_AB1;
                SEL_GPIO_LEVEL: next_source = SRC_GPIO;
                default: next_source = SRC_NONE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // readback selection
    // ------------------------------------------------------------
    logic isReadSelect;
    // special mode with readback function code
    assign isReadSelect = frameWord[MODE_TOP:MODE_TOP-1] == MODE_SPECIAL
        && frameWord[FUNC_TOP:FUNC_LOW] == FUNC_READ_SELECT;

    // selection held for the following frame only
    always_ff @(posedge clk) begin
        if (srst) begin
            source <= SRC_NONE;
            chanSel <= '{kind: 2'h0, channel: 3'h0};
        end else if (frameDone) begin
            source <= isReadSelect ? next_source : SRC_NONE;
            chanSel <= next_chan;
        end else if (!syncB.syncN && !frameActive) begin
            // each frame uses the selection up as it starts
            source <= SRC_NONE;
        end
    end

    // ------------------------------------------------------------
    // readback mux
    // ------------------------------------------------------------
    logic [15:0] next_readWord;
    // selected register, zero when nothing is chosen
    always_comb begin
        case (source)
            SRC_CHANNEL:
                next_readWord = channelWord[chanSel.kind][chanSel.channel];
            SRC_CONTROL: next_readWord = {11'h000, controlValue};
            SRC_GROUP0: next_readWord = {2'h0, group0OffsetValue};
            SRC_GROUP1: next_readWord = {2'h0, group1OffsetValue};
            SRC_AB0: next_readWord = {12'h000, abGroup0};
            SRC_AB1: next_readWord = {12'h000, abGroup1};
            SRC_GPIO: next_readWord = {15'h0000, gpioB};
            default: next_readWord = WORD_RESET;
        endcase
    end

    // ------------------------------------------------------------
    // output shifter
    // ------------------------------------------------------------
    // readback word in the low sixteen bits, eight zeros above
    logic [FRAME_BITS-1:0] shiftOut;

    // load at frame start, shift on rising sclk
    always_ff @(posedge clk) begin
        if (srst) begin
            shiftOut <= '0;
            sdo <= 1'b0;
        end else if (!syncB.syncN && !frameActive) begin
            shiftOut <= {8'h00, next_readWord};
            sdo <= 1'b0;
        end else if (!syncB.syncN && sclkRise) begin
            sdo <= shiftOut[FRAME_BITS-1];
            shiftOut <= {shiftOut[FRAME_BITS-2:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    logic wbHit;
    // a request is taken once, in the cycle before ack
    assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    logic [5:0] wbWordIndex;
    logic [2:0] wbChan;
    logic [1:0] wbKind;
    logic wbChanHit;
    // channel window: four words per channel, one per type
    assign wbChanHit = wb_adr_i >= ADDR_CHAN_BASE
        && wb_adr_i < ADDR_CHAN_BASE + 8'(4 * 4 * CHANNELS);
    assign wbWordIndex = wb_adr_i[7:2] - ADDR_CHAN_BASE[7:2];
    assign wbKind = wbWordIndex[1:0];
    assign wbChan = 3'(wbWordIndex[5:2]);

    // write side: control, offsets, a/b selects
    always_ff @(posedge clk) begin
        if (srst) begin
            controlValue <= CONTROL_RESET;
            group0OffsetValue <= '0;
            group1OffsetValue <= '0;
            abGroup0 <= 4'h0;
            abGroup1 <= 4'h0;
        end else if (wbHit && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                ADDR_CONTROL: controlValue <= wb_dat_i[4:0];
                ADDR_GROUP0_OFFSET:
                    group0OffsetValue <= wb_dat_i[13:0];
                ADDR_GROUP1_OFFSET:
                    group1OffsetValue <= wb_dat_i[13:0];
                ADDR_AB_GROUP0: abGroup0 <= wb_dat_i[3:0];
                ADDR_AB_GROUP1: abGroup1 <= wb_dat_i[3:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // channel word array
    // ------------------------------------------------------------
    // channel word array, one entry per type and channel
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int k = 0; k < 4; k++) begin
                for (int c = 0; c < CHANNELS; c++) begin
                    channelWord[k][c] <= WORD_RESET;
                end
            end
        end else if (wbHit && wb_we_i && wbChanHit) begin
            if (wb_sel_i[0]) begin
                channelWord[wbKind][wbChan][7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                channelWord[wbKind][wbChan][15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // read data and single-cycle ack; unmapped reads as zero
    always_ff @(posedge clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wbHit;
            wb_dat_o <= '0;
            if (wbHit && !wb_we_i) begin
                if (wbChanHit) begin
                    wb_dat_o <= {16'h0000, channelWord[wbKind][wbChan]};
                end else begin
                    case (wb_adr_i)
                        ADDR_STATUS:
                            wb_dat_o <= {26'h0, gpioB, 2'h0, source};
                        ADDR_CONTROL: wb_dat_o <= {27'h0, controlValue};
                        ADDR_GROUP0_OFFSET:
                            wb_dat_o <= {18'h0, group0OffsetValue};
                        ADDR_GROUP1_OFFSET:
                            wb_dat_o <= {18'h0, group1OffsetValue};
                        ADDR_AB_GROUP0: wb_dat_o <= {28'h0, abGroup0};
                        ADDR_AB_GROUP1: wb_dat_o <= {28'h0, abGroup1};
                        default: wb_dat_o <= '0;
                    endcase
                end
            end
        end
    end

endmodule : readback_register_select
`default_nettype wire

// File: dv/readback_select_assertions.sv
// checker: bus and link timing assertions for the readback block
`timescale 1ns/1ps
`default_nettype none
module readback_select_checker
    import readback_select_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire readback_select_pkg::serial_in_type serialIn,
    input wire logic gpioLevel,
    input wire logic sdo,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    logic [3:0] quiet = 4'hF;
    // cycles since the last sclk or syncN edge, saturating
    always_ff @(posedge clk) begin
        if ($changed(serialIn.sclk) || $changed(serialIn.syncN)) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hF) begin
            quiet <= quiet + 4'h1;
        end
    end
    sequence busReq;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence rdStatus;
        wb_ack_o && !wb_we_i && wb_adr_i == ADDR_STATUS;
    endsequence
    ack_latency_a: assert property (busReq |=> wb_ack_o)
        else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
        else $error("upper read bits set");
    unmapped_zero_a: assert property (wb_ack_o &&
        wb_adr_i inside {[8'h18:8'h3F]} |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    status_pin_a: assert property (
        $stable(gpioLevel) [*8] ##0 rdStatus
        |-> wb_dat_o[5] == gpioLevel && wb_dat_o[4:3] == 2'h0)
        else $error("status pin level wrong");
    sdo_timing_a: assert property ($changed(sdo) |-> quiet < 4'h8)
        else $error("sdo moved without link edge");
endmodule : readback_select_checker
bind readback_register_select readback_select_checker #(.CHANNELS(CHANNELS))
    i_chk (.clk(clk), .srst(srst), .serialIn(serialIn),
    .gpioLevel(gpioLevel), .sdo(sdo), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));
`default_nettype wire

// File: dv/link_host_model.sv
// host model: serial master sending frames and capturing readback
`timescale 1ns/1ps
`default_nettype none
module link_host_model (
    input wire logic clk,
    input wire logic sdo,
    output var readback_select_pkg::serial_in_type serialIn,
    output var logic [23:0] frameData,
    output var logic frameDone
);
    import readback_select_pkg::*;
    logic inFrame = 1'b0;
    // idle pins: clock still, frame high, data keeps changing
    initial begin
        serialIn = 3'h2;
        frameData = 24'h0;
        frameDone = 1'b0;
    end
    // idle data toggles so nothing leans on a stale bit
    always #5 begin
        if (!inFrame) serialIn.sdi = ~serialIn.sdi;
    end
    task automatic send(input logic [23:0] tx);
        int i;
        @(posedge clk);
        #1;
        inFrame = 1'b1;
        serialIn.syncN = 1'b0;
        // msb first; data moves with the rising edge so that
        // it stands still across the falling edge that is sampled
        for (i = 23; i >= 0; i--) begin
            #40 serialIn.sclk = 1'b1;
            serialIn.sdi = tx[i];
            #40 frameData[i] = sdo;
            serialIn.sclk = 1'b0;
        end
        #40 serialIn.syncN = 1'b1;
        inFrame = 1'b0;
        #100;
        @(posedge clk);
        frameDone <= 1'b1;
        @(posedge clk);
        frameDone <= 1'b0;
    endtask : send
endmodule : link_host_model
`default_nettype wire

// File: dv/readback_register_select_tb_top.sv
// testbench: readback selection over wishbone and the serial link
`timescale 1ns/1ps
`default_nettype none
module readback_register_select_tb_top;
    import readback_select_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic gpioLevel = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, sdo, frameDone;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic [23:0] frameData;
    logic [15:0] lfsr = 16'h003C;
    serial_in_type serialIn;
    int miscompares = 0, compares = 0;
    logic [31:0] busQ[$];
    logic [23:0] frameQ[$];
    logic [7:0] regAdr[5] = '{ADDR_CONTROL, ADDR_GROUP0_OFFSET,
        ADDR_GROUP1_OFFSET, ADDR_AB_GROUP0, ADDR_AB_GROUP1};
    logic [8:0] regSel[5] = '{SEL_CONTROL, SEL_GROUP0_OFFSET,
        SEL_GROUP1_OFFSET, SEL_AB_GROUP0, SEL_AB_GROUP1};
    logic [15:0] regMask[5] = '{16'h001F, 16'h3FFF, 16'h3FFF, 16'h000F,
        16'h000F};
    always #2.5 clk = ~clk;
    readback_register_select #(.CHANNELS(8)) i_dut (.clk(clk), .srst(srst),
        .serialIn(serialIn), .gpioLevel(gpioLevel), .sdo(sdo),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
    link_host_model i_host (.clk(clk), .sdo(sdo), .serialIn(serialIn),
        .frameData(frameData), .frameDone(frameDone));
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction : rnd
    task automatic cmp_bus(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED bus read exp %h got %h", e, g);
        end
    endtask : cmp_bus
    task automatic cmp_frame(input logic [23:0] e, input logic [23:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED frame exp %h got %h", e, g);
        end
    endtask : cmp_frame
    // result watcher: oldest note against each answer
    always @(negedge clk) begin
        if (ack === 1'b1 && we === 1'b0) cmp_bus(busQ.pop_front(), rdat);
        if (frameDone === 1'b1) cmp_frame(frameQ.pop_front(), frameData);
    end
    task automatic wb(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        // hold the request until ack; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        busQ.push_back(e);
        wb(a, 1'b0, 32'h0);
    endtask : rd
    task automatic readback(input logic [8:0] c, input logic [6:0] lo,
        input logic [15:0] e);
        frameQ.push_back(24'h0);
        frameQ.push_back({8'h00, e});
        i_host.send({MODE_SPECIAL, FUNC_READ_SELECT, c, lo});
        i_host.send({MODE_SPECIAL, FUNC_NOP, 16'h0000});
    endtask : readback
    task automatic wrap_up();
        // any notes never answered count as one mismatch
        if (busQ.size() != 0 || frameQ.size() != 0) miscompares++;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    // main sequence
    initial begin
        int t;
        logic [15:0] v;
        logic [7:0] a;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (t = 0; t < 5; t++) rd(regAdr[t], 32'h0);
        wb(8'h20, 1'b1, 32'hFFFF);
        rd(8'h20, 32'h0);
        $display("test reset done");
        for (t = 0; t < 5; t++) begin
            v = rnd() & regMask[t];
            wb(regAdr[t], 1'b1, {16'h0, v});
            rd(regAdr[t], {16'h0, v});
            readback(regSel[t], 7'(rnd()),
                v);
        end
        for (t = 0; t < 4; t++) begin
            v = rnd();
            a = ADDR_CHAN_BASE + 8'(32 * t + 4 * t + 16);
            wb(a, 1'b1, {16'h0, v});
            readback({3'(t), CHAN_BASE + 6'(2 * t + 1)}, 7'(rnd()),
                v);
        end
        readback({3'h0, 6'h07}, 7'h00, 16'h0000);
        readback(9'h104, 7'h00, 16'h0000);
        frameQ.push_back(24'h0);
        frameQ.push_back(24'h0);
        i_host.send({MODE_SPECIAL, 6'h04, SEL_CONTROL, 7'h00});
        i_host.send({MODE_SPECIAL, FUNC_NOP, 16'h0000});
        $display("test select done");
        for (t = 0; t < 2; t++) begin
            gpioLevel <= t[0];
            frameQ.push_back(24'h0);
            frameQ.push_back({23'h0, t[0]});
            i_host.send({MODE_SPECIAL, FUNC_READ_SELECT, SEL_GPIO_LEVEL, 7'h00});
            rd(ADDR_STATUS, {26'h0, t[0], 2'h0, SRC_GPIO});
            i_host.send({MODE_SPECIAL, FUNC_NOP, 16'h0000});
        end
        $display("test pin done");
        repeat (10) @(posedge clk);
        wrap_up();
    end
    // watchdog well past the expected run
    initial begin
        #300000;
        miscompares++;
        wrap_up();
    end
endmodule : readback_register_select_tb_top
`default_nettype wire
